//--- pwg_pilot_wire_pwm.sv
`timescale 1ns/10ps
`include "pwg_defines.svh"

module pwg_pilot_wire_pwm (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire pwg_pkg::pwg_duty_cfg_t dutyCfg,
  input  wire pwg_pkg::pwg_ctrl_t    ctrl,
  input  wire logic                  faultInputPin,
  output logic                       pilotOut,
  output logic                       faultIrq,
  output logic                       periodStart
);
  import pwg_pkg::*;

  // ----------------------------------------
  // subsystem clock enable
  // ----------------------------------------
  // fractional accumulator: 25.16 MHz average tick rate from 200 MHz
  logic [`PWG_ACC_W-1:0] acc;
  logic [`PWG_ACC_W:0]   accSum;
  wire                   subTick;
  assign accSum  = {1'b0, acc} + {1'b0, `PWG_SUBCLK_NUM};
  assign subTick = (accSum >= {1'b0, `PWG_SUBCLK_DEN});

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= '0;
    end else if (subTick) begin
      acc <= accSum[`PWG_ACC_W-1:0] - `PWG_SUBCLK_DEN;
    end else begin
      acc <= accSum[`PWG_ACC_W-1:0];
    end
  end

  // ----------------------------------------
  // period counter
  // ----------------------------------------
  logic [`PWG_CNT_W-1:0] cnt;
  wire                   atLast;
  assign atLast = (cnt == `PWG_PERIOD_LAST);

  // free running from reset, independent of the output enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (subTick) begin
      cnt <= atLast ? '0 : cnt + 15'h0001;
    end
  end

  // ----------------------------------------
  // duty compare
  // ----------------------------------------
  logic [`PWG_CNT_W-1:0] pendDuty;
  logic [`PWG_CNT_W-1:0] activeDuty;
  wire  [`PWG_CNT_W-1:0] reqDuty;
  wire                   wrapTick;
  wire  [`PWG_CNT_W-1:0] clampDuty;
  assign reqDuty   = dutyCfg.useRuntime ? dutyCfg.duty : `PWG_DUTY_DEFAULT;
  // clamp keeps the duty a fraction of the period
  assign clampDuty = (reqDuty > `PWG_PERIOD_LAST) ? `PWG_PERIOD_LAST : reqDuty;
  assign wrapTick  = subTick && atLast;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendDuty <= `PWG_DUTY_DEFAULT;
    end else if (dutyCfg.load || !dutyCfg.useRuntime) begin
      pendDuty <= clampDuty;
    end
  end

  // shadow swap only on wrap, so no runt pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      activeDuty <= `PWG_DUTY_DEFAULT;
    end else if (wrapTick) begin
      activeDuty <= pendDuty;
    end
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  pwg_state_t state;
  pwg_state_t next_state;
  wire        pwmLevel;
  wire        next_pilot;
  assign pwmLevel = (cnt < activeDuty);
  // enable waits for the boundary so the first pulse is whole
  always_comb begin
    next_state = state;
    unique case (state)
      PWG_IDLE: if (ctrl.outEnable && wrapTick) next_state = PWG_RUN;
      PWG_RUN:  if (!ctrl.outEnable) next_state = PWG_IDLE;
    endcase
  end
  assign next_pilot = (state == PWG_RUN) ? pwmLevel : 1'b1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= PWG_IDLE;
      pilotOut    <= 1'b1;
      periodStart <= 1'b0;
    end else begin
      state       <= next_state;
      pilotOut    <= next_pilot;
      periodStart <= wrapTick;
    end
  end

  // ----------------------------------------
  // ground fault interrupt
  // ----------------------------------------
  logic faultPrev;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultPrev <= 1'b0;
      faultIrq  <= 1'b0;
    end else begin
      faultPrev <= faultInputPin;
      faultIrq  <= ctrl.faultIrqEnable && faultInputPin && !faultPrev;
    end
  end
endmodule

//--- pwg_defines.svh
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH

// ----------------------------------------
// clock and period
// ----------------------------------------
`define PWG_SUBCLK_KHZ      25160
`define PWG_PILOT_KHZ       1
`define PWG_PERIOD_COUNTS   (`PWG_SUBCLK_KHZ / `PWG_PILOT_KHZ)
`define PWG_CNT_W           15
`define PWG_PERIOD_LAST     15'h6247
`define PWG_DUTY_DEFAULT    15'h3126
`define PWG_SUBCLK_NUM      16'h0275
`define PWG_SUBCLK_DEN      16'h1388
`define PWG_ACC_W           16

`endif

//--- pwg_pkg.sv
package pwg_pkg;
  `include "pwg_defines.svh"

  typedef struct packed {
    logic                  useRuntime;
    logic [`PWG_CNT_W-1:0] duty;
    logic                  load;
  } pwg_duty_cfg_t;

  typedef struct packed {
    logic outEnable;
    logic faultIrqEnable;
  } pwg_ctrl_t;

  typedef enum logic [1:0] {
    PWG_IDLE,
    PWG_RUN
  } pwg_state_t;
endpackage

//--- pwg_ev_pilot_model.sv
`timescale 1ns/10ps
module pwg_ev_pilot_model (
  input  logic        clk,
  input  logic        pilotLine,
  output logic [17:0] hiClk
);
  logic [17:0] run = '0;
  always @(posedge clk) begin
    run <= pilotLine ? run + 18'h00001 : '0;
    if (!pilotLine && run != 0) hiClk <= run;
  end
endmodule

//--- pwg_pilot_monitor.sv
`timescale 1ns/10ps
module pwg_pilot_monitor (
  input logic               clk,
  input logic               sys_rst,
  input pwg_pkg::pwg_ctrl_t ctrl,
  input logic               faultInputPin,
  input logic               pilotOut,
  input logic               faultIrq,
  input logic               periodStart
);
  import pwg_pkg::*;
  // starts negative so the partial first period is skipped
  int cnt;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) cnt <= 32'hfff9e580;
    else cnt <= periodStart ? 1 : cnt + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rise; !faultInputPin ##1 faultInputPin && ctrl.faultIrqEnable; endsequence
  a_irq_cause: assert property (s_rise |=> faultIrq) else $error("no irq");
  a_irq_gate: assert property (faultIrq |-> $past(ctrl.faultIrqEnable)) else $error("stray irq");
  a_irq_once: assert property (faultIrq |=> !faultIrq) else $error("long irq");
  a_start_once: assert property (periodStart |=> !periodStart) else $error("long start");
  a_period_len: assert property (periodStart && cnt > 0 |-> cnt inside {[32'h30d3f:32'h30d41]})
    else $error("bad period");
  a_idle_high: assert property ((!ctrl.outEnable)[*4] |-> pilotOut) else $error("low idle");
  a_fall_gate: assert property ($fell(pilotOut) |-> $past(ctrl.outEnable, 2)) else $error("early");
  a_rise_wrap: assert property ($rose(pilotOut) && ctrl.outEnable |-> periodStart || $past(periodStart))
    else $error("rise off wrap");
endmodule
bind pwg_pilot_wire_pwm pwg_pilot_monitor mon (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl),
  .faultInputPin(faultInputPin), .pilotOut(pilotOut), .faultIrq(faultIrq), .periodStart(periodStart));

//--- tb_pilot_wire_pwm_generator.sv
`timescale 1ns/10ps
`include "pwg_defines.svh"
`define CHK(a,b) begin checkCount++; if ((a)!==(b)) begin errorCnt++; $display("[ERR] %0t %h %h",$time,a,b); end end
module tb_pilot_wire_pwm_generator;
  import pwg_pkg::*;
  logic          clk = 0, sysRst = 1, pin = 0, pilot, irq, ps;
  pwg_duty_cfg_t cfg = '0;
  pwg_ctrl_t     ctl = '0;
  logic [17:0]   hi;
  int            errorCnt, checkCount, cyc, n;
  pwg_pilot_wire_pwm dut (.clk(clk), .sys_rst(sysRst), .dutyCfg(cfg), .ctrl(ctl), .faultInputPin(pin),
    .pilotOut(pilot), .faultIrq(irq), .periodStart(ps));
  pwg_ev_pilot_model ev (.clk(clk), .pilotLine(pilot), .hiClk(hi));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc > 1300000) begin
    errorCnt++;
    report_and_stop();
  end
  task report_and_stop;
    if (errorCnt == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(int k);
    repeat (k) @(negedge clk);
  endtask
  task waitPs;
    while (ps !== 1) tick(1);
    tick(1);
  endtask
  task fault(bit en);
    ctl.faultIrqEnable = en;
    pin = 1;
    n = 0;
    repeat (4) begin
      tick(1);
      n += irq;
    end
    pin = 0;
    tick(2);
    `CHK(n, en)
  endtask
  // duty field is the same in both calls, so only the select decides
  task duty(bit rt, int d);
    cfg = '{rt, 15'h1000, 1};
    ctl.outEnable = 1;
    tick(1);
    cfg.load = 0;
    waitPs;
    waitPs;
    while (pilot !== 0) tick(1);
    tick(2);
    `CHK(hi + 2 - d * 5000 / 629 <= 4, 1)
  endtask
  initial begin
    tick(5);
    sysRst = 0;
    `CHK(pilot, 1)
    waitPs;
    `CHK(pilot, 1)
    fault(0);
    fault(1);
    duty(0, `PWG_DUTY_DEFAULT);
    duty(1, 32'h1000);
    ctl.outEnable = 0;
    tick(3);
    `CHK(pilot, 1)
    report_and_stop();
  end
endmodule
